// [common/acr_pkg.sv]
// Package: register map, field layout, timing and types of the converter control block
package acr_pkg;

  // Register byte addresses
  localparam logic [3:0] ACR_CTRL_ADDR = 4'h0; // conversion_control
  localparam logic [3:0] ACR_STAT_ADDR = 4'h4; // conversion_control_status
  localparam logic [3:0] ACR_CHAN_ADDR = 4'h8; // channel select

  // conversion_control field positions
  localparam int ACR_TRG_HI = 7;
  localparam int ACR_TRG_LO = 6;
  localparam int ACR_SCAN_EN = 5;
  localparam int ACR_SCAN_SZ = 4;
  localparam int ACR_CKS_HI = 3;
  localparam int ACR_CKS_LO = 2;
  localparam int ACR_AUTOCLR = 1;
  localparam int ACR_RSVD = 0;

  // Status field positions
  localparam int ACR_ST_DONE = 7;
  localparam int ACR_ST_START = 5;
  localparam int ACR_ST_EXT = 4;
  localparam int ACR_ST_BUSY = 0;

  // Reset values
  localparam logic [7:0] ACR_CTRL_RST = 8'h00;
  localparam logic [3:0] ACR_CHAN_RST = 4'h0;

  // Trigger select encodings
  localparam logic [1:0] ACR_TRG_OFF = 2'h0;
  localparam logic [1:0] ACR_TRG_PULSE = 2'h1;
  localparam logic [1:0] ACR_TRG_TIMER8 = 2'h2;

  // Group last-channel offsets and group start masks
  localparam logic [3:0] ACR_GRP4_LAST = 4'h3;
  localparam logic [3:0] ACR_GRP8_LAST = 4'h7;
  localparam logic [3:0] ACR_GRP4_MASK = 4'hc;
  localparam logic [3:0] ACR_GRP8_MASK = 4'h8;

  // Maximum conversion time in system states per {extension, clock select}
  localparam logic [9:0] ACR_T000 = 10'd528;
  localparam logic [9:0] ACR_T001 = 10'd268;
  localparam logic [9:0] ACR_T010 = 10'd138;
  localparam logic [9:0] ACR_T011 = 10'd73;
  localparam logic [9:0] ACR_T100 = 10'd336;
  localparam logic [9:0] ACR_T101 = 10'd172;
  localparam logic [9:0] ACR_T110 = 10'd90;
  localparam logic [9:0] ACR_T111 = 10'd49;

  // Conversion clock divider: divide code to terminal count
  localparam logic [2:0] ACR_DIV8_TC = 3'h7;
  localparam logic [2:0] ACR_DIV4_TC = 3'h3;
  localparam logic [2:0] ACR_DIV2_TC = 3'h1;
  localparam logic [2:0] ACR_DIV1_TC = 3'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_CONV = 2'b01,
    ACR_GAP = 2'b10
  } acr_state_type;

  // Decoded control fields
  typedef struct packed {
    logic [1:0] trg_sel;
    logic scan_en;
    logic scan_size;
    logic [1:0] clk_sel;
    logic auto_clear;
    logic rsvd;
  } acr_ctrl_type;

endpackage : acr_pkg

// [core/acr_clkdiv.sv]
// Conversion clock enable generator with selectable divide ratio
`timescale 1ns/1ps
module acr_clkdiv
  import acr_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [1:0] clk_sel_i,
  // Tick out
  output logic tick_o
);

  logic [2:0] cnt;
  logic [2:0] tc;

  assign tc = (clk_sel_i == 2'h0) ? ACR_DIV8_TC :
              (clk_sel_i == 2'h1) ? ACR_DIV4_TC :
              (clk_sel_i == 2'h2) ? ACR_DIV2_TC : ACR_DIV1_TC;
  assign tick_o = run_i && (cnt == tc);

  // Free counter, restarted while idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i || tick_o)
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'h1;
  end

  AST_DIV_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o && clk_sel_i == 2'h1 && $stable(clk_sel_i) ##1 run_i [*3] |-> !tick_o)
    else $error("divide by four tick too early");

endmodule : acr_clkdiv

// [core/acr_timer.sv]
// Conversion time counter: counts one conversion to its documented maximum
`timescale 1ns/1ps
module acr_timer
  import acr_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic clk_ext_i,
  input wire logic [1:0] clk_sel_i,
  // Status
  output logic busy_o,
  output logic end_o
);

  logic [9:0] cnt;
  logic [9:0] limit;

  assign limit = clk_ext_i ?
    ((clk_sel_i == 2'h0) ? ACR_T100 : (clk_sel_i == 2'h1) ? ACR_T101 :
     (clk_sel_i == 2'h2) ? ACR_T110 : ACR_T111) :
    ((clk_sel_i == 2'h0) ? ACR_T000 : (clk_sel_i == 2'h1) ? ACR_T001 :
     (clk_sel_i == 2'h2) ? ACR_T010 : ACR_T011);
  // Start cycle counts as the first state, so the last busy count is limit minus two
  assign end_o = busy_o && (cnt == limit - 10'd2);

  // Count states of one conversion
  always_ff @(posedge clk_i)
  begin
    if (rst_i || abort_i || end_o)
    begin
      busy_o <= 1'b0;
      cnt <= 10'h0;
    end
    else if (start_i && !busy_o)
    begin
      busy_o <= 1'b1;
      cnt <= 10'h0;
    end
    else if (busy_o)
      cnt <= cnt + 10'd1;
  end

endmodule : acr_timer

// [core/acr_ctrl.sv]
// Converter control register logic with Wishbone slave and conversion sequencer
// What this block does
// - Trigger select 00 ignores timer triggers; 11 must not be written.
// - Select 10 starts conversion on an eight-bit timer pulse.
// - Scan enable 0 gives single mode; scan with size 1 covers up to eight, ending at the selected channel.
// - Scan enable 1 with size 0 scans up to four channels of a group, ending at the selected one.
// - Clock select 00..11 divides system clock by eight, four, two, one.
// - Without extension conversion lasts at most 528, 268, 138, 73 states.
// - With extension conversion lasts at most 336, 172, 90, 49 states.
// - Auto clear 0: scan keeps repeating until software clears start.
// - Auto clear 1: start clears after the whole group, then stops.
// - Lowest control bit is reserved, read/write, reset 0.
// - Single mode clears start at end; software clear halts conversion.
// - Automatic start clear happens a cycle before the done flag.
// - Four-channel scan starts at channel 0, 4, 8 or 12 by upper bits.
`timescale 1ns/1ps
module acr_ctrl
  import acr_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Trigger sources
  input wire logic pulse_timer_trig_i,
  input wire logic timer8_trig_i,
  // Conversion core side
  output logic conv_tick_o,
  output logic conv_start_o,
  output logic [3:0] conv_channel_o,
  output logic conv_end_o
);

  acr_state_type state;
  acr_state_type next_state;
  acr_ctrl_type ctrl;
  logic [3:0] chan_sel;
  logic start_bit;
  logic done_flag;
  logic done_pend;
  logic [3:0] cur_ch;
  logic tmr_busy;
  logic tmr_end;
  logic ack_q;
  logic clk_ext;

  // Bus decode
  wire req = cyc_i && stb_i && !ack_q && !err_o;
  wire hit_ctrl = adr_i == ACR_CTRL_ADDR;
  wire hit_stat = adr_i == ACR_STAT_ADDR;
  wire hit_chan = adr_i == ACR_CHAN_ADDR;
  wire mapped = hit_ctrl || hit_stat || hit_chan;
  wire wr_lane0 = req && we_i && sel_i[0] && mapped;
  wire wr_ctrl = wr_lane0 && hit_ctrl;
  wire wr_stat = wr_lane0 && hit_stat;
  wire wr_chan = wr_lane0 && hit_chan;

  // Trigger qualification
  // select 00 ignores triggers
  wire trig_pulse = (ctrl.trg_sel == ACR_TRG_PULSE) && pulse_timer_trig_i;
  wire trig_t8 = (ctrl.trg_sel == ACR_TRG_TIMER8) && timer8_trig_i;
  wire ext_trig = trig_pulse || trig_t8;
  wire sw_start = wr_stat && dat_i[ACR_ST_START] && !start_bit;
  wire sw_stop = wr_stat && !dat_i[ACR_ST_START];

  // Group geometry
  // scan group size
  wire [3:0] grp_last = ctrl.scan_size ? ACR_GRP8_LAST : ACR_GRP4_LAST;
  wire [3:0] grp_first = ctrl.scan_size ? (chan_sel & ACR_GRP8_MASK) : (chan_sel & ACR_GRP4_MASK);
  wire [3:0] grp_end = grp_first | (chan_sel & grp_last);
  wire last_ch = !ctrl.scan_en || (cur_ch == grp_end);
  wire seq_end = tmr_end && last_ch;
  wire hw_clear = seq_end && (!ctrl.scan_en || ctrl.auto_clear);

  // Bus read mux
  wire [7:0] stat_byte = {done_flag, 1'b0, start_bit, clk_ext, 3'h0, tmr_busy};
  wire [7:0] rd_byte = hit_ctrl ? ctrl : hit_stat ? stat_byte : {4'h0, chan_sel};

  // Bus answer: one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_q <= req && mapped;
      err_o <= req && !mapped;
      dat_o <= {24'h0, rd_byte};
    end
  end
  assign ack_o = ack_q;

  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= ACR_CTRL_RST;
    else if (wr_ctrl)
      ctrl <= dat_i[7:0];
  end

  // Clock extension bit, kept in the status byte
  // extension select stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clk_ext <= 1'b0;
    else if (wr_stat)
      clk_ext <= dat_i[ACR_ST_EXT];
  end

  // Channel select register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chan_sel <= ACR_CHAN_RST;
    else if (wr_chan)
      chan_sel <= dat_i[3:0];
  end

  // Start bit: hardware clear, software write, triggers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_bit <= 1'b0;
    // end of single conversion or of a one-cycle scan group clears start
    else if (hw_clear)
      start_bit <= 1'b0;
    else if (sw_stop)
      start_bit <= 1'b0;
    else if (sw_start || ext_trig)
      start_bit <= 1'b1;
  end

  // Done flag, set one cycle after start clear; set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_pend <= 1'b0;
      done_flag <= 1'b0;
    end
    else
    begin
      done_pend <= seq_end;
      if (done_pend)
        done_flag <= 1'b1;
      else if (wr_stat && !dat_i[ACR_ST_DONE])
        done_flag <= 1'b0;
    end
  end

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      ACR_IDLE: if (start_bit) next_state = ACR_CONV;
      ACR_CONV:
      begin
        if (!start_bit) next_state = ACR_IDLE;
        else if (tmr_end) next_state = ACR_GAP;
      end
      ACR_GAP: next_state = start_bit ? ACR_CONV : ACR_IDLE;
      default: next_state = ACR_IDLE;
    endcase
  end

  // Sequencer state and current channel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ACR_IDLE;
      cur_ch <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (state == ACR_IDLE)
        cur_ch <= ctrl.scan_en ? grp_first : chan_sel;
      // wrap to group start while start stays set
      else if (tmr_end)
        cur_ch <= last_ch ? (ctrl.scan_en ? grp_first : chan_sel) : cur_ch + 4'h1;
    end
  end

  assign conv_start_o = (state == ACR_CONV) && !tmr_busy && start_bit;
  assign conv_end_o = tmr_end;
  assign conv_channel_o = cur_ch;

  // Conversion time counter
  acr_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(conv_start_o),
    .abort_i(!start_bit),
    .clk_ext_i(clk_ext),
    .clk_sel_i(ctrl.clk_sel),
    .busy_o(tmr_busy),
    .end_o(tmr_end)
  );

  // Conversion clock enable
  acr_clkdiv u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(tmr_busy),
    .clk_sel_i(ctrl.clk_sel),
    .tick_o(conv_tick_o)
  );

  // Checks
  // no start from triggers when disabled
  AST_TRIG_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl.trg_sel == ACR_TRG_OFF && !start_bit && !sw_start |=> !start_bit)
    else $error("start set with triggers disabled");
  AST_TRIG_T8: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_t8 && !hw_clear && !sw_stop |=> start_bit)
    else $error("timer8 trigger ignored");
  AST_TRIG_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_pulse && !hw_clear && !sw_stop |=> start_bit)
    else $error("pulse timer trigger ignored");
  AST_SINGLE_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_end && !ctrl.scan_en |=> !start_bit)
    else $error("single mode start not cleared");
  AST_SCAN_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_end && ctrl.scan_en && !ctrl.auto_clear && !wr_stat |=> start_bit)
    else $error("continuous scan start cleared");
  // one-cycle scan clears at group end
  AST_SCAN_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_end && ctrl.scan_en && ctrl.auto_clear |=> !start_bit)
    else $error("one-cycle scan start not cleared");
  AST_FLAG_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_clear |=> !done_flag || $past(done_flag) ##1 done_flag)
    else $error("done flag not after start clear");
  AST_GRP4: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ACR_CONV && ctrl.scan_en && !ctrl.scan_size |-> cur_ch[3:2] == chan_sel[3:2])
    else $error("channel outside four-group");
  AST_RESET: assert property (@(posedge clk_i) $past(rst_i) |-> ctrl == ACR_CTRL_RST && !start_bit)
    else $error("control not zero after reset");

  COV_SINGLE: cover property (@(posedge clk_i) hw_clear && !ctrl.scan_en);
  COV_SCAN4: cover property (@(posedge clk_i) seq_end && ctrl.scan_en && !ctrl.scan_size);
  COV_SCAN8: cover property (@(posedge clk_i) seq_end && ctrl.scan_en && ctrl.scan_size);
  COV_TRIG: cover property (@(posedge clk_i) ext_trig && !start_bit);

endmodule : acr_ctrl

// [sim/acr_partner.sv]
// Partner model: timer trigger sources and conversion core observer
`timescale 1ns/1ps
module acr_partner
  import acr_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench commands
  input wire logic fire_pulse_i,
  input wire logic fire_timer8_i,
  // Conversion core side
  input wire logic conv_tick_i,
  input wire logic conv_start_i,
  input wire logic conv_end_i,
  input wire logic [3:0] conv_channel_i,
  // Trigger outputs
  output logic pulse_timer_trig_o,
  output logic timer8_trig_o,
  // Observations
  output logic [15:0] end_cnt_o,
  output logic [15:0] last_len_o,
  output logic [7:0] tick_gap_o,
  output logic [15:0] chan_log_o
);
  logic [15:0] len_run;
  logic [7:0] gap_run;
  // One-cycle pulses, quiet during reset
  // timer trigger sources
  always_ff @(posedge clk_i)
  begin
    pulse_timer_trig_o <= fire_pulse_i & ~rst_i;
    timer8_trig_o <= fire_timer8_i & ~rst_i;
  end
  // Conversion length and channel order at each end, tick spacing at each tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      end_cnt_o <= 16'h0000;
      last_len_o <= 16'h0000;
      tick_gap_o <= 8'h00;
      chan_log_o <= 16'h0000;
      len_run <= 16'h0000;
      gap_run <= 8'h00;
    end
    else
    begin
      len_run <= conv_start_i ? 16'h0001 : len_run + 16'h0001;
      gap_run <= conv_tick_i ? 8'h01 : gap_run + 8'h01;
      if (conv_tick_i)
        tick_gap_o <= gap_run;
      if (conv_end_i)
      begin
        end_cnt_o <= end_cnt_o + 16'h0001;
        last_len_o <= conv_start_i ? 16'h0001 : len_run + 16'h0001; // Inclusive count
        chan_log_o <= {chan_log_o[11:0], conv_channel_i};
      end
    end
  end
endmodule : acr_partner

// [sim/tb_adc_control_register_logic.sv]
// Testbench: bus-level regression of the converter control block
`timescale 1ns/1ps
module tb_adc_control_register_logic
  import acr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fp = 1'b0, ft = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, err_o, ptt, t8t, tick, cst, cend, e;
  logic [3:0] ch;
  logic [15:0] ecnt, len, clog, tgt;
  logic [7:0] gap, q;
  int error_cnt = 0, total_checks = 0, cyc_cnt = 0;
  int mx[8] = '{528, 268, 138, 73, 336, 172, 90, 49};
  int mn[8] = '{518, 262, 134, 69, 326, 166, 86, 45};
  int dv[4] = '{8, 4, 2, 1};

  acr_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .pulse_timer_trig_i(ptt),
    .timer8_trig_i(t8t), .conv_tick_o(tick), .conv_start_o(cst), .conv_channel_o(ch), .conv_end_o(cend));
  acr_partner far (.clk_i(clk_i), .rst_i(rst_i), .fire_pulse_i(fp), .fire_timer8_i(ft), .conv_tick_i(tick),
    .conv_start_i(cst), .conv_end_i(cend), .conv_channel_i(ch), .pulse_timer_trig_o(ptt),
    .timer8_trig_o(t8t), .end_cnt_o(ecnt), .last_len_o(len), .tick_gap_o(gap), .chan_log_o(clog));

  // Clock and hang guard
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 30000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude;
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    total_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic chk_rng(input logic [15:0] g, input int lo, input int hi);
    total_checks++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, hi);
    end
  endtask : chk_rng

  // Classic single Wishbone cycle, held until ack or err
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    sel <= 4'h1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, n, 1);
    end
    q = dat_o[7:0];
    e = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  // One-cycle trigger request to the partner
  task automatic fire(input logic pulse);
    @(posedge clk_i);
    fp <= pulse;
    ft <= ~pulse;
    @(posedge clk_i);
    fp <= 1'b0;
    ft <= 1'b0;
  endtask : fire

  task automatic wait_ends(input logic [15:0] x);
    int n;
    n = 0;
    while (ecnt !== x && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(ecnt, x);
  endtask : wait_ends

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(ACR_CTRL_ADDR, 1'b0, 8'h00);
    chk(q, 8'h00);
    bus(ACR_CTRL_ADDR, 1'b1, 8'h01);
    bus(ACR_CTRL_ADDR, 1'b0, 8'h00);
    chk(q, 8'h01);
    bus(ACR_CTRL_ADDR, 1'b1, 8'hbc);
    bus(ACR_CTRL_ADDR, 1'b0, 8'h00);
    chk(q, 8'hbc);
    bus(4'hc, 1'b1, 8'h55);
    chk(e, 1'b1);
    bus(ACR_CTRL_ADDR, 1'b1, 8'h0c);
    fire(1'b1);
    fire(1'b0);
    bus(ACR_STAT_ADDR, 1'b0, 8'h00);
    chk(q & 8'h20, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      bus(ACR_CTRL_ADDR, 1'b1, {4'h0, k[1:0], 2'b00});
      tgt = ecnt + 16'h0001;
      bus(ACR_STAT_ADDR, 1'b1, {3'b001, k[2], 4'h0});
      wait_ends(tgt);
      chk_rng(len, mn[k], mx[k]);
      chk(gap, dv[k[1:0]]);
      bus(ACR_STAT_ADDR, 1'b0, 8'h00);
      chk(q & 8'ha0, 8'h80);
    end
    for (int t = 1; t < 3; t++)
    begin
      bus(ACR_CTRL_ADDR, 1'b1, {t[1:0], 6'h0c});
      tgt = ecnt + 16'h0001;
      fire(t == 2);
      bus(ACR_STAT_ADDR, 1'b0, 8'h00);
      chk(q & 8'h20, 8'h00);
      fire(t == 1);
      wait_ends(tgt);
    end
    bus(ACR_CHAN_ADDR, 1'b1, 8'h06);
    bus(ACR_CTRL_ADDR, 1'b1, 8'h2e);
    tgt = ecnt + 16'h0003;
    bus(ACR_STAT_ADDR, 1'b1, 8'h20);
    wait_ends(tgt);
    repeat (600) @(posedge clk_i);
    chk(ecnt, tgt);
    chk(clog & 16'h0fff, 16'h0456);
    bus(ACR_STAT_ADDR, 1'b0, 8'h00);
    chk(q & 8'h20, 8'h00);
    bus(ACR_CHAN_ADDR, 1'b1, 8'h02);
    bus(ACR_CTRL_ADDR, 1'b1, 8'h3c);
    tgt = ecnt + 16'h0004;
    bus(ACR_STAT_ADDR, 1'b1, 8'h20);
    wait_ends(tgt);
    chk(clog, 16'h0120);
    bus(ACR_STAT_ADDR, 1'b0, 8'h00);
    chk(q & 8'h20, 8'h20);
    bus(ACR_STAT_ADDR, 1'b1, 8'h00);
    repeat (10) @(posedge clk_i);
    tgt = ecnt;
    repeat (600) @(posedge clk_i);
    chk(ecnt, tgt);
    bus(ACR_CHAN_ADDR, 1'b1, 8'h05);
    bus(ACR_CTRL_ADDR, 1'b1, 8'h1c);
    tgt = ecnt + 16'h0001;
    bus(ACR_STAT_ADDR, 1'b1, 8'h20);
    wait_ends(tgt);
    repeat (600) @(posedge clk_i);
    chk(ecnt, tgt);
    chk(clog & 16'h000f, 16'h0005);
    bus(ACR_CTRL_ADDR, 1'b1, 8'h0c);
    bus(ACR_CTRL_ADDR, 1'b0, 8'h00);
    chk(q, 8'h0c);
    conclude();
  end
endmodule : tb_adc_control_register_logic
